/* rtl/measure_pkg.sv */
// Notes on behaviour
// R1: Gated mode counts clocks while signal high
// R2: Gated mode: window rise after first captures period
// R3: Counter mode counts signal input pulses
// R4: Counter mode: window fall captures pulse width
// R5: Status bit 7 requests period capture update
// R6: Status bit 6 requests width capture update
// R7: Status bit 4 resets counter, clears when done
// R8: Status bit 2 shows counter incrementing
// R9: Status bit 1 shows window open
// R10: Status bit 0 shows acquisition in progress
// R11: Window and go inputs synchronised first
package measure_pkg;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 12;
  localparam logic [11:0] STATUS_OFS = 12'h49A;
  localparam logic [11:0] PERIOD_CAP0_OFS = 12'h4A0;
  localparam logic [11:0] PERIOD_CAP1_OFS = 12'h4A1;
  localparam logic [11:0] PERIOD_CAP2_OFS = 12'h4A2;
  localparam logic [11:0] WIDTH_CAP0_OFS = 12'h4A3;
  localparam logic [11:0] WIDTH_CAP1_OFS = 12'h4A4;
  localparam logic [11:0] WIDTH_CAP2_OFS = 12'h4A5;
  localparam logic [11:0] COUNT0_OFS = 12'h4A6;
  localparam logic [11:0] COUNT1_OFS = 12'h4A7;
  localparam logic [11:0] COUNT2_OFS = 12'h4A8;
  localparam logic [11:0] CONTROL_OFS = 12'h4A9;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h4AA;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h4AB;
  localparam int PERIOD_UPD_BIT = 7;
  localparam int WIDTH_UPD_BIT = 6;
  localparam int COUNT_RST_BIT = 4;
  localparam int COUNTING_BIT = 2;
  localparam int WINDOW_BIT = 1;
  localparam int ACQ_BIT = 0;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_GO_BIT = 1;
  localparam int CTL_MODE_BIT = 2;
  localparam int IRQ_PERIOD_BIT = 0;
  localparam int IRQ_WIDTH_BIT = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'hD0;
  localparam logic MODE_GATED = 1'b0;
  localparam logic MODE_COUNTER = 1'b1;
endpackage

/* rtl/level_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module level_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic async,
  output logic      synced
);
  logic stage1Reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1Reg <= 1'b0;
      synced    <= 1'b0;
    end else begin
      stage1Reg <= async;
      synced    <= stage1Reg;
    end
  end
endmodule
`default_nettype wire

/* rtl/edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module edge_detect (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prevReg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) prevReg <= 1'b0;
    else       prevReg <= level;
  end

  assign rise = level & ~prevReg;
  assign fall = ~level & prevReg;
endmodule
`default_nettype wire

/* rtl/signal_measure_timer.sv */
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module signal_measure_timer (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        signalIn,
  input  wire logic        windowInput,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [7:0]  rdData,
  output logic             irq
);
  localparam int W = measure_pkg::CNT_W;

  logic          windowSync;
  logic          goSync;
  logic          signalSync;
  logic          winRise;
  logic          winFall;
  logic          sigRise;
  logic          unusedSigFall;
  logic          unusedGoRise;
  logic          unusedGoFall;
  logic [W-1:0]  measureCounter_reg;
  logic [W-1:0]  measureCounter_next;
  logic [W-1:0]  periodCapture_reg;
  logic [W-1:0]  widthCapture_reg;
  logic [7:0]    control_reg;
  logic [7:0]    irqMask_reg;
  logic [7:0]    irqStatus_reg;
  logic [7:0]    irqStatus_next;
  logic          periodUpdReq_reg;
  logic          widthUpdReq_reg;
  logic          countRstReq_reg;
  logic          seenFirstRise_reg;
  logic          counting_reg;
  logic          acqActive_reg;
  logic [7:0]    rdData_next;
  logic          irq_next;

  // Go is a software bit but still crosses through the synchroniser so that
  // counting starts on the same clock grid as the window sampling
  level_sync goSyncInst (
    .clk    (clk),
    .nrst   (nrst),
    .async  (control_reg[measure_pkg::CTL_GO_BIT]),
    .synced (goSync)
  ); // [R11]

  level_sync winSyncInst (
    .clk    (clk),
    .nrst   (nrst),
    .async  (windowInput),
    .synced (windowSync)
  ); // [R11]

  level_sync sigSyncInst (
    .clk    (clk),
    .nrst   (nrst),
    .async  (signalIn),
    .synced (signalSync)
  );

  edge_detect winEdgeInst (
    .clk  (clk),
    .nrst (nrst),
    .level(windowSync),
    .rise (winRise),
    .fall (winFall)
  );

  edge_detect sigEdgeInst (
    .clk  (clk),
    .nrst (nrst),
    .level(signalSync),
    .rise (sigRise),
    .fall (unusedSigFall)
  );

  edge_detect goEdgeInst (
    .clk  (clk),
    .nrst (nrst),
    .level(goSync),
    .rise (unusedGoRise),
    .fall (unusedGoFall)
  );

  wire enabled    = control_reg[measure_pkg::CTL_EN_BIT];
  wire run        = enabled & goSync;
  wire modeCount  = control_reg[measure_pkg::CTL_MODE_BIT] == measure_pkg::MODE_COUNTER;
  // Counter mode samples the signal on this clock; pulses narrower than one
  // clock can be missed, traded against keeping a single clock domain
  wire incGated   = run & ~modeCount & signalSync; // [R1]
  wire incCount   = run & modeCount & sigRise;     // [R3]
  wire periodCap  = run & ~modeCount & winRise & seenFirstRise_reg; // [R2]
  wire widthCap   = run & modeCount & winFall;     // [R4]
  wire isWrite    = wrStb;
  wire statusWr   = isWrite & (addr == measure_pkg::STATUS_OFS);
  wire controlWr  = isWrite & (addr == measure_pkg::CONTROL_OFS);
  wire maskWr     = isWrite & (addr == measure_pkg::IRQ_MASK_OFS);
  wire irqRd      = rdStb & (addr == measure_pkg::IRQ_STATUS_OFS);
  wire [7:0] statusView = {periodUpdReq_reg, widthUpdReq_reg, 1'b0, countRstReq_reg,
                           1'b0, counting_reg, windowSync, acqActive_reg};

  function automatic logic [7:0] byteOf(input logic [W-1:0] v, input logic [1:0] idx);
    byteOf = v[8*idx +: 8];
  endfunction

  always_comb begin
    measureCounter_next = measureCounter_reg;
    if (countRstReq_reg)
      measureCounter_next = '0; // [R7]
    else if (periodCap)
      // The sample on the capture edge opens the next window, so no clock falls between windows
      measureCounter_next = incGated ? W'(1) : '0; // [R1] [R2]
    else if (incGated || incCount)
      measureCounter_next = measureCounter_reg + W'(1); // [R1] [R3]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) measureCounter_reg <= '0;
    else       measureCounter_reg <= measureCounter_next;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) periodCapture_reg <= '0;
    else if (periodCap || periodUpdReq_reg) periodCapture_reg <= measureCounter_reg; // [R2] [R5]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) widthCapture_reg <= '0;
    else if (widthCap || widthUpdReq_reg) widthCapture_reg <= measureCounter_reg; // [R4] [R6]
  end

  // Request bits are set by software and self-clear one cycle later once done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodUpdReq_reg <= 1'b0;
      widthUpdReq_reg  <= 1'b0;
      countRstReq_reg  <= 1'b0;
    end else begin
      periodUpdReq_reg <= statusWr & wrData[measure_pkg::PERIOD_UPD_BIT]; // [R5]
      widthUpdReq_reg  <= statusWr & wrData[measure_pkg::WIDTH_UPD_BIT];  // [R6]
      countRstReq_reg  <= statusWr & wrData[measure_pkg::COUNT_RST_BIT];  // [R7]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seenFirstRise_reg <= 1'b0;
      counting_reg      <= 1'b0;
      acqActive_reg     <= 1'b0;
    end else begin
      if (!run) seenFirstRise_reg <= 1'b0;
      else if (winRise) seenFirstRise_reg <= 1'b1; // [R2]
      counting_reg  <= incGated | incCount; // [R8]
      acqActive_reg <= run;                 // [R10]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_reg <= measure_pkg::CONTROL_RST;
      irqMask_reg <= measure_pkg::IRQ_MASK_RST;
    end else begin
      if (controlWr) control_reg <= wrData;
      if (maskWr)    irqMask_reg <= wrData;
    end
  end

  // Set wins over the clear-on-read in the same cycle
  always_comb begin
    irqStatus_next = irqRd ? 8'h00 : irqStatus_reg;
    irqStatus_next[measure_pkg::IRQ_PERIOD_BIT] = irqStatus_next[measure_pkg::IRQ_PERIOD_BIT] | periodCap;
    irqStatus_next[measure_pkg::IRQ_WIDTH_BIT]  = irqStatus_next[measure_pkg::IRQ_WIDTH_BIT] | widthCap;
  end

  always_comb begin
    rdData_next = 8'h00;
    if (rdStb) begin
      unique case (addr)
        measure_pkg::STATUS_OFS:      rdData_next = statusView; // [R8] [R9] [R10]
        measure_pkg::PERIOD_CAP0_OFS: rdData_next = byteOf(periodCapture_reg, 2'd0);
        measure_pkg::PERIOD_CAP1_OFS: rdData_next = byteOf(periodCapture_reg, 2'd1);
        measure_pkg::PERIOD_CAP2_OFS: rdData_next = byteOf(periodCapture_reg, 2'd2);
        measure_pkg::WIDTH_CAP0_OFS:  rdData_next = byteOf(widthCapture_reg, 2'd0);
        measure_pkg::WIDTH_CAP1_OFS:  rdData_next = byteOf(widthCapture_reg, 2'd1);
        measure_pkg::WIDTH_CAP2_OFS:  rdData_next = byteOf(widthCapture_reg, 2'd2);
        measure_pkg::COUNT0_OFS:      rdData_next = byteOf(measureCounter_reg, 2'd0);
        measure_pkg::COUNT1_OFS:      rdData_next = byteOf(measureCounter_reg, 2'd1);
        measure_pkg::COUNT2_OFS:      rdData_next = byteOf(measureCounter_reg, 2'd2);
        measure_pkg::CONTROL_OFS:     rdData_next = control_reg;
        measure_pkg::IRQ_STATUS_OFS:  rdData_next = irqStatus_reg;
        measure_pkg::IRQ_MASK_OFS:    rdData_next = irqMask_reg;
        default:                      rdData_next = 8'h00;
      endcase
    end
  end

  assign irq_next = |(irqStatus_next & irqMask_reg);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus_reg <= 8'h00;
      rdData        <= 8'h00;
      irq           <= 1'b0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      rdData        <= rdData_next;
      irq           <= irq_next;
    end
  end

  chk_period_capture_load: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    periodCap |=> periodCapture_reg == $past(measureCounter_reg) &&
                  measureCounter_reg == (($past(incGated) && !$past(countRstReq_reg)) ? W'(1) : W'(0)))
    else $error("period capture did not load and clear");
  chk_width_capture_load: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    widthCap |=> widthCapture_reg == $past(measureCounter_reg))
    else $error("width capture did not load");
  chk_gated_count_step: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    incGated && !countRstReq_reg && !periodCap |=> measureCounter_reg == $past(measureCounter_reg) + W'(1))
    else $error("gated count did not advance");
  chk_counter_hold_idle: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    run && modeCount && !sigRise && !countRstReq_reg |=> $stable(measureCounter_reg))
    else $error("counter mode advanced without pulse");
  chk_period_req_clear: assert property (@(posedge clk) disable iff (!nrst) // [R5]
    statusWr && wrData[7] |=> periodUpdReq_reg ##1 (!periodUpdReq_reg || $past(statusWr)))
    else $error("period update request did not clear");
  chk_width_req_load: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    widthUpdReq_reg |=> widthCapture_reg == $past(measureCounter_reg))
    else $error("width manual update failed");
  chk_counter_reset_done: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    countRstReq_reg |=> measureCounter_reg == '0)
    else $error("counter reset failed");
  chk_acq_status_run: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    run |=> acqActive_reg)
    else $error("acquisition status wrong");
  chk_counting_status: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    (incGated || incCount) |=> counting_reg)
    else $error("counting status wrong");
  chk_window_status_view: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    rdStb && addr == measure_pkg::STATUS_OFS |=> rdData[1] == $past(windowSync))
    else $error("window status wrong");
  chk_width_req_clear: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    widthUpdReq_reg |=> !widthUpdReq_reg || $past(statusWr && wrData[measure_pkg::WIDTH_UPD_BIT]))
    else $error("width update request did not clear");
  chk_reset_req_clear: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    countRstReq_reg |=> !countRstReq_reg || $past(statusWr && wrData[measure_pkg::COUNT_RST_BIT]))
    else $error("counter reset request did not clear");
  chk_period_req_load: assert property (@(posedge clk) disable iff (!nrst) // [R5]
    periodUpdReq_reg |=> periodCapture_reg == $past(measureCounter_reg))
    else $error("period manual update failed");
  chk_first_rise_skip: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    run && !modeCount && winRise && !seenFirstRise_reg && !periodUpdReq_reg |=> $stable(periodCapture_reg))
    else $error("first window rise captured a period");
  chk_counting_idle: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    !(incGated || incCount) |=> !counting_reg)
    else $error("counting status set while idle");
  chk_acq_status_idle: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    !run |=> !acqActive_reg)
    else $error("acquisition status set while stopped");
  chk_irq_level_out: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> irq == $past(irq_next))
    else $error("interrupt output wrong");
  chk_read_idle_zero: assert property (@(posedge clk) disable iff (!nrst)
    !rdStb |=> rdData == 8'h00)
    else $error("read data not zero outside a read");

  cov_period_capture: cover property (@(posedge clk) disable iff (!nrst) periodCap);
  cov_width_capture: cover property (@(posedge clk) disable iff (!nrst) widthCap);
  cov_irq_raised: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
  cov_manual_update: cover property (@(posedge clk) disable iff (!nrst) periodUpdReq_reg);
  cov_counter_pulse: cover property (@(posedge clk) disable iff (!nrst) incCount);
endmodule
`default_nettype wire

/* verification/signal_source.sv */
`timescale 1ns/100ps
`default_nettype none
module signal_source (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic [3:0] hiLen,
  input  wire logic [3:0] loLen,
  output var logic        sigOut
);
  initial sigOut = 1'b0;
  // Whole-cycle pulses of hiLen clocks, so the input sync cannot drop one
  always @(posedge clk) begin
    if (start) begin
      repeat (pulses) begin
        sigOut <= 1'b1;
        repeat (hiLen) @(posedge clk);
        sigOut <= 1'b0;
        repeat (loLen) @(posedge clk);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/signal_measure_timer_test.sv */
`timescale 1ns/100ps
`default_nettype none
module signal_measure_timer_test;
  logic        clk;
  logic        nrst;
  logic        signalIn;
  logic        windowInput;
  logic [11:0] addr;
  logic [7:0]  wrData;
  logic        wrStb;
  logic        rdStb;
  logic [7:0]  rdData;
  logic        irq;
  logic        start;
  logic [7:0]  pulses;
  logic [3:0]  hiLen;
  logic [3:0]  loLen;
  logic [7:0]  rdv;
  int          error_cnt;
  int          compares;
  // Write flag, address, write data or expected read data
  logic [20:0] rows [12] = '{21'h049A00, 21'h04A900, 21'h04AB00, 21'h04AA00, 21'h04A600, 21'h04A000,
                             21'h04A300, 21'h012300, 21'h1123FF, 21'h012300, 21'h149A07, 21'h049A00};

  signal_measure_timer u_dut (.clk(clk), .nrst(nrst), .signalIn(signalIn), .windowInput(windowInput),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq));
  signal_source u_src (.clk(clk), .start(start), .pulses(pulses), .hiLen(hiLen), .loLen(loLen),
    .sigOut(signalIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    rdv = rdData;
    chk(n, rdv & m, e);
  endtask

  task automatic win(input logic v, input int n);
    @(posedge clk);
    windowInput <= v;
    repeat (n - 1) @(posedge clk);
  endtask

  task automatic st(input logic [7:0] p, input logic [3:0] h, input logic [3:0] l);
    @(posedge clk);
    start  <= 1'b1;
    pulses <= p;
    hiLen  <= h;
    loLen  <= l;
    @(posedge clk);
    start  <= 1'b0;
  endtask

  initial begin
    int i;
    nrst = 1'b0;
    windowInput = 1'b0;
    addr = 12'h000;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
    start = 1'b0;
    pulses = 8'h00;
    hiLen = 4'h0;
    loLen = 4'h0;
    error_cnt = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k][20])
        wr(rows[k][19:8], rows[k][7:0]);
      else
        rchk("register", rows[k][19:8], 8'hFF, rows[k][7:0]);
    end
    // Gated run: 3 of every 8 clocks high, window period 32, so 12 counts per window
    wr(12'h4A9, 8'h03);
    st(8'hFF, 4'h3, 4'h5);
    win(1'b1, 40);
    rchk("period first", 12'h4A0, 8'hFF, 8'h00);
    rchk("window open", 12'h49A, 8'h03, 8'h03);
    win(1'b0, 20);
    rchk("window shut", 12'h49A, 8'h02, 8'h00);
    win(1'b1, 16);
    win(1'b0, 16);
    win(1'b1, 8);
    rchk("period gated", 12'h4A0, 8'hFF, 8'h0C);
    rchk("period mid", 12'h4A1, 8'hFF, 8'h00);
    rchk("irq status", 12'h4AA, 8'hFF, 8'h01);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(12'h4AB, 8'h01);
    win(1'b0, 8);
    win(1'b1, 1);
    for (i = 0; i < 64 && irq !== 1'b1; i++) @(posedge clk);
    if (i == 64) begin
      error_cnt++;
      wrap_up();
    end
    rchk("irq status", 12'h4AA, 8'hFF, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    repeat (2000) @(posedge clk);
    // Counter mode: pulses counted on the signal, width caught at window fall
    wr(12'h4A9, 8'h07);
    win(1'b1, 8);
    wr(12'h49A, 8'h10);
    rchk("counter reset", 12'h4A6, 8'hFF, 8'h00);
    st(8'h05, 4'h2, 4'h2);
    repeat (30) @(posedge clk);
    win(1'b0, 8);
    rchk("width", 12'h4A3, 8'hFF, 8'h05);
    rchk("counter", 12'h4A6, 8'hFF, 8'h05);
    wr(12'h49A, 8'h80);
    rchk("period manual", 12'h4A0, 8'hFF, 8'h05);
    st(8'h03, 4'h2, 4'h2);
    repeat (20) @(posedge clk);
    wr(12'h49A, 8'h40);
    rchk("width manual", 12'h4A3, 8'hFF, 8'h08);
    rchk("period held", 12'h4A0, 8'hFF, 8'h05);
    rchk("status done", 12'h49A, 8'hD5, 8'h01);
    wr(12'h49A, 8'h10);
    rchk("counter reset", 12'h4A6, 8'hFF, 8'h00);
    rchk("reset done", 12'h49A, 8'h10, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
